// ---- mhr_pkg.sv ----
/*
 * mhr_pkg: constants, types and register map of the message handshake reporter.
 * Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM register bus.
 */
package mhr_pkg;

    localparam int unsigned MHR_AW          = 5;
    localparam logic [4:0]  MHR_OFS_CTRL    = 5'h00;
    localparam logic [4:0]  MHR_OFS_STATUS  = 5'h04;
    localparam logic [4:0]  MHR_OFS_IRQ_EN  = 5'h08;
    localparam logic [4:0]  MHR_OFS_IRQ_CLR = 5'h0C;
    localparam logic [4:0]  MHR_OFS_TXCNT   = 5'h10;

    localparam int unsigned MHR_CTRL_MODE   = 0;
    localparam int unsigned MHR_CTRL_POL    = 1;
    localparam int unsigned MHR_CTRL_ERRH   = 2;
    localparam logic [2:0]  MHR_CTRL_RST    = 3'h2;

    localparam int unsigned MHR_ST_BUSY     = 8;
    localparam int unsigned MHR_ST_SEQ      = 9;
    localparam int unsigned MHR_NIRQ        = 4;
    localparam int unsigned MHR_IRQ_BUSY    = 0;
    localparam int unsigned MHR_IRQ_READY   = 1;
    localparam int unsigned MHR_IRQ_TMO     = 2;
    localparam int unsigned MHR_IRQ_ERR     = 3;

    localparam logic [7:0]  MHR_XOFF        = 8'h13;
    localparam logic [7:0]  MHR_XON         = 8'h11;
    localparam logic [7:0]  MHR_ZERO        = 8'h30;
    localparam logic [9:0]  MHR_NUM_MAX     = 10'h3E7;
    localparam int unsigned MHR_NBYTES      = 5;

    typedef enum logic [3:0] {
        MHR_SRC_AUTO   = 4'h0,
        MHR_SRC_CHAIN  = 4'h1,
        MHR_SRC_DEF    = 4'h2,
        MHR_SRC_ERR    = 4'h3,
        MHR_SRC_INDEX  = 4'h4,
        MHR_SRC_LINK   = 4'h5,
        MHR_SRC_PORT   = 4'h6,
        MHR_SRC_PERIOD = 4'h7,
        MHR_SRC_QUEUE  = 4'h8,
        MHR_SRC_RESET  = 4'h9,
        MHR_SRC_TIMER  = 4'hA,
        MHR_SRC_UPDATE = 4'hB
    } mhr_src_t;

    typedef enum logic [2:0] {
        MHR_EV_REQ      = 3'h0,
        MHR_EV_DONE     = 3'h1,
        MHR_EV_ITEMWAIT = 3'h2,
        MHR_EV_SERTERM  = 3'h3,
        MHR_EV_PARFULL  = 3'h4,
        MHR_EV_TIMEOUT  = 3'h5,
        MHR_EV_ERROR    = 3'h6
    } mhr_ev_t;

    typedef struct packed {
        logic       valid;
        mhr_ev_t    kind;
        mhr_src_t   src;
        logic [9:0] num;
    } mhr_evt_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [MHR_AW-1:0] address;
        logic [31:0]       writedata;
    } mhr_avm_t;

    typedef enum logic [1:0] {
        MHR_S_IDLE = 2'b01,
        MHR_S_SEND = 2'b10
    } mhr_state_t;

endpackage

// ---- mhr_reporter.sv ----
/*
 * mhr_reporter: busy/ready handshake reporter of the message display.
 * Assumes the message engine presents one event at a time and holds it
 * until evt_ready; the serial transmitter takes a byte on tx_valid&tx_ready.
 */
// What this block does
// - one of two protocols selected by mode
// - send XOFF when busy, XON when ready
// - request sends XOFF, source letter, three digits
// - message finished sends XON
// - awaiting item without request string sends XON
// - serial item terminator received sends XOFF
// - parallel item byte count reached sends XOFF
// - port timeout sends XOFF on close
// - source letters a c d e i l m p q r t u
// - character mode always transmits error codes
// - linked message is just the next request event, nothing repeats
// - hardware mode pin follows busy and ready
// - positive logic conducts ready, negative conducts busy
// - pin busy on request, ready when done
// - pin ready when port item awaited
// - pin busy on terminator or byte count
`timescale 1ns/1ps

module mhr_reporter
    import mhr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire mhr_avm_t    avm,
    output logic             avm_waitrequest,
    output logic [31:0]      avm_readdata,
    input  wire mhr_evt_t    evt,
    output logic             evt_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe_n,
    output logic             irq
);

    typedef struct packed {
        mhr_state_t                    state;
        logic [2:0]                    ctrl;
        logic [MHR_NIRQ-1:0]           status;
        logic [MHR_NIRQ-1:0]           irq_en;
        logic                          irq;
        logic                          busy;
        logic                          pin_oe_n;
        logic [MHR_NBYTES-1:0][7:0]    bytes;
        logic [2:0]                    left;
        logic                          tx_valid;
        logic [7:0]                    tx_data;
        logic                          evt_ready;
        logic [31:0]                   txcnt;
        logic                          wait_n;
        logic [31:0]                   rdata;
    } mhr_regs_t;

    mhr_regs_t st_reg;
    mhr_regs_t st_next;

    // source letter lookup
    function automatic logic [7:0] src_char(input mhr_src_t s);
        case (s)
            MHR_SRC_AUTO:   src_char = 8'h61;
            MHR_SRC_CHAIN:  src_char = 8'h63;
            MHR_SRC_DEF:    src_char = 8'h64;
            MHR_SRC_ERR:    src_char = 8'h65;
            MHR_SRC_INDEX:  src_char = 8'h69;
            MHR_SRC_LINK:   src_char = 8'h6C;
            MHR_SRC_PORT:   src_char = 8'h6D;
            MHR_SRC_PERIOD: src_char = 8'h70;
            MHR_SRC_QUEUE:  src_char = 8'h71;
            MHR_SRC_RESET:  src_char = 8'h72;
            MHR_SRC_TIMER:  src_char = 8'h74;
            MHR_SRC_UPDATE: src_char = 8'h75;
            default:        src_char = 8'h3F;
        endcase
    endfunction

    // three ASCII digits, hundreds first; numbers above 999 are clamped
    function automatic logic [2:0][7:0] digits(input logic [9:0] n);
        logic [9:0] r;
        logic [3:0] h;
        logic [3:0] t;
        r = (n > MHR_NUM_MAX) ? MHR_NUM_MAX : n;
        h = 4'h0;
        t = 4'h0;
        for (int k = 0; k < 9; k++) begin
            if (r >= 10'd100) begin
                r = r - 10'd100;
                h = h + 4'h1;
            end
        end
        for (int k = 0; k < 9; k++) begin
            if (r >= 10'd10) begin
                r = r - 10'd10;
                t = t + 4'h1;
            end
        end
        digits[2] = MHR_ZERO + {4'h0, h};
        digits[1] = MHR_ZERO + {4'h0, t};
        digits[0] = MHR_ZERO + {4'h0, r[3:0]};
    endfunction

    logic       char_mode;
    logic       take_evt;
    logic       bus_go;
    logic [2:0] dig_unused;

    assign char_mode  = ~st_reg.ctrl[MHR_CTRL_MODE];
    assign take_evt   = evt.valid & st_reg.evt_ready;
    assign bus_go     = (avm.read | avm.write) & ~st_reg.wait_n;
    assign dig_unused = {pin_in, 2'b00};

    always_comb begin
        logic [2:0][7:0]       d;
        logic                  conduct;
        logic [MHR_NIRQ-1:0]   ev;
        logic [MHR_NIRQ-1:0]   clr;
        d       = digits(evt.num);
        conduct = 1'b0;
        ev      = '0;
        clr     = '0;
        st_next = st_reg;

        // bus slave: one wait cycle, then a single-cycle answer
        st_next.wait_n = bus_go;
        if (bus_go && avm.read) begin
            case (avm.address)
                MHR_OFS_CTRL:   st_next.rdata = {29'h0, st_reg.ctrl};
                MHR_OFS_STATUS: st_next.rdata = {22'h0, (st_reg.state == MHR_S_SEND),
                                                 st_reg.busy, 4'h0, st_reg.status};
                MHR_OFS_IRQ_EN: st_next.rdata = {28'h0, st_reg.irq_en};
                MHR_OFS_TXCNT:  st_next.rdata = st_reg.txcnt;
                default:        st_next.rdata = 32'h0000_0000;
            endcase
        end
        if (avm.write && st_reg.wait_n) begin
            case (avm.address)
                MHR_OFS_CTRL:    st_next.ctrl   = avm.writedata[2:0];
                MHR_OFS_IRQ_EN:  st_next.irq_en = avm.writedata[MHR_NIRQ-1:0];
                MHR_OFS_IRQ_CLR: clr            = avm.writedata[MHR_NIRQ-1:0];
                default:         ;
            endcase
        end

        // event acceptance; bytes load with the last to send at index 0
        if (take_evt) begin
            st_next.left = 3'd0;
            case (evt.kind)
                MHR_EV_REQ: begin
                    st_next.busy  = 1'b1;
                    st_next.bytes = {MHR_XOFF, src_char(evt.src), d};
                    st_next.left  = 3'd5;
                end
                MHR_EV_DONE, MHR_EV_ITEMWAIT: begin
                    st_next.busy     = 1'b0;
                    st_next.bytes[0] = MHR_XON;
                    st_next.left     = 3'd1;
                end
                MHR_EV_SERTERM, MHR_EV_PARFULL, MHR_EV_TIMEOUT: begin
                    st_next.busy     = 1'b1;
                    st_next.bytes[0] = MHR_XOFF;
                    st_next.left     = 3'd1;
                    ev[MHR_IRQ_TMO]  = (evt.kind == MHR_EV_TIMEOUT);
                end
                MHR_EV_ERROR: begin
                    // error codes go out regardless of the error-handling bit
                    st_next.bytes[3:0] = {src_char(MHR_SRC_ERR), d};
                    st_next.left       = 3'd4;
                    ev[MHR_IRQ_ERR]    = 1'b1;
                end
                default: ;
            endcase
            // in hardware mode nothing goes out on the serial line
            if (!char_mode) begin
                st_next.left = 3'd0;
            end
            ev[MHR_IRQ_BUSY]  = st_next.busy & ~st_reg.busy;
            ev[MHR_IRQ_READY] = ~st_next.busy & st_reg.busy;
        end

        // byte sequencer; a linked message is just the next request event
        case (st_reg.state)
            MHR_S_IDLE: begin
                if (take_evt && st_next.left != 3'd0) begin
                    st_next.state     = MHR_S_SEND;
                    st_next.evt_ready = 1'b0;
                end else begin
                    st_next.evt_ready = 1'b1;
                end
            end
            MHR_S_SEND: begin
                if (!st_reg.tx_valid || tx_ready) begin
                    if (st_reg.tx_valid) begin
                        st_next.txcnt = st_reg.txcnt + 32'h0000_0001;
                    end
                    if (st_reg.left == 3'd0) begin
                        st_next.tx_valid  = 1'b0;
                        st_next.state     = MHR_S_IDLE;
                        st_next.evt_ready = 1'b1;
                    end else begin
                        st_next.tx_valid = 1'b1;
                        st_next.tx_data  = st_reg.bytes[st_reg.left - 3'd1];
                        st_next.left     = st_reg.left - 3'd1;
                    end
                end
            end
            default: begin
                st_next.state     = MHR_S_IDLE;
                st_next.tx_valid  = 1'b0;
                st_next.evt_ready = 1'b1;
            end
        endcase

        // open-collector pin, only in hardware mode
        if (!char_mode) begin
            conduct = st_reg.ctrl[MHR_CTRL_POL] ? ~st_next.busy : st_next.busy;
        end
        st_next.pin_oe_n = ~conduct;

        // sticky status: a new event beats a clear in the same cycle
        st_next.status = (st_reg.status & ~clr) | ev;
        st_next.irq    = |(st_next.status & st_next.irq_en);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg           <= '0;
            st_reg.state     <= MHR_S_IDLE;
            st_reg.ctrl      <= MHR_CTRL_RST;
            st_reg.pin_oe_n  <= 1'b1;
            st_reg.evt_ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avm_waitrequest = ~st_reg.wait_n;
    assign avm_readdata    = st_reg.rdata;
    assign evt_ready       = st_reg.evt_ready;
    assign tx_valid        = st_reg.tx_valid;
    assign tx_data         = st_reg.tx_data;
    assign pin_out         = dig_unused[0] & 1'b0;
    assign pin_oe_n        = st_reg.pin_oe_n;
    assign irq             = st_reg.irq;

endmodule

// ---- mhr_reporter_assertions.sv ----
/* mhr_reporter_assertions: port-level checks of the handshake reporter.
   assumes one clock and the synchronous active-low reset of the top module. */
`timescale 1ns/1ps
module mhr_reporter_assertions
    import mhr_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire mhr_avm_t   avm,
    input wire logic       avm_waitrequest,
    input wire mhr_evt_t   evt,
    input wire logic       evt_ready,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_ready,
    input wire logic       pin_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire take = evt.valid && evt_ready;
    property p_wait;
        (avm.read || avm.write) && avm_waitrequest |=> !avm_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    property p_stand;
        !avm_waitrequest |=> avm_waitrequest;
    endproperty
    a_stand: assert property (p_stand) else $error("bus answer too long");
    property p_req;
        take && evt.kind == MHR_EV_REQ ##2 tx_valid |-> tx_data == MHR_XOFF;
    endproperty
    a_req: assert property (p_req) else $error("request not led by busy byte");
    property p_xon;
        take && evt.kind inside {MHR_EV_DONE, MHR_EV_ITEMWAIT} ##2 tx_valid
            |-> tx_data == MHR_XON;
    endproperty
    a_xon: assert property (p_xon) else $error("ready byte missing");
    property p_xoff;
        take && evt.kind inside {MHR_EV_SERTERM, MHR_EV_PARFULL, MHR_EV_TIMEOUT}
            ##2 tx_valid |-> tx_data == MHR_XOFF;
    endproperty
    a_xoff: assert property (p_xoff) else $error("busy byte missing");
    property p_err;
        take && evt.kind == MHR_EV_ERROR ##2 tx_valid |-> tx_data == 8'h65;
    endproperty
    a_err: assert property (p_err) else $error("error code missing");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped in stall");
    property p_busy;
        tx_valid |-> !evt_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("event taken mid sequence");
    property p_oc;
        pin_out == 1'b0;
    endproperty
    a_oc: assert property (p_oc) else $error("pin driven high");
endmodule

bind mhr_reporter mhr_reporter_assertions u_chk (.clk(clk), .rstn(rstn), .avm(avm),
    .avm_waitrequest(avm_waitrequest), .evt(evt), .evt_ready(evt_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .pin_out(pin_out));

// ---- mhr_host_model.sv ----
/* mhr_host_model: controlling host taking the reporter's byte stream.
   assumes one byte moves on each edge with tx_valid and tx_ready high. */
`timescale 1ns/1ps
module mhr_host_model (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            got,
    output logic [7:0]      rx_byte
);
    int seed = 32'h088a_9a6e;
    initial tx_ready = 1'b0;
    initial got = 1'b0;
    // random stalls prove the byte is held until taken
    always @(posedge clk) begin
        got <= tx_valid && tx_ready;
        rx_byte <= tx_data;
        tx_ready <= $random(seed) % 2 != 0;
    end
endmodule

// ---- mhr_reporter_tb.sv ----
/* mhr_reporter_tb: drives bus and events, queues expected bytes, checks pin and irq.
   assumes the host model takes the stream and the pin is pulled up. */
`timescale 1ns/1ps
module mhr_reporter_tb;
    import mhr_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    mhr_avm_t    avm = '0;
    mhr_evt_t    evt = '0;
    logic        wreq, erdy, txv, txr, got, pout, poe_n, irq;
    logic [31:0] rdat, q;
    logic [7:0]  txd, rxb;
    logic [7:0]  expq[$];
    int          n_errors = 0;
    int          comparisons = 0;
    int          sent = 0;
    int          seed = 32'h088a_9a6e;
    logic        mode = 1'b0;
    logic        pos = 1'b1;
    logic        busy = 1'b0;
    string       lt = "acdeilmpqrtu";
    mhr_ev_t     sq[6] = '{MHR_EV_SERTERM, MHR_EV_ITEMWAIT, MHR_EV_PARFULL,
                           MHR_EV_ITEMWAIT, MHR_EV_TIMEOUT, MHR_EV_DONE};
    always #5 clk = ~clk;
    mhr_reporter dut (.clk(clk), .rstn(rstn), .avm(avm), .avm_waitrequest(wreq),
        .avm_readdata(rdat), .evt(evt), .evt_ready(erdy), .tx_valid(txv), .tx_data(txd),
        .tx_ready(txr), .pin_in(poe_n), .pin_out(pout), .pin_oe_n(poe_n), .irq(irq));
    mhr_host_model host (.clk(clk), .tx_valid(txv), .tx_data(txd), .tx_ready(txr),
        .got(got), .rx_byte(rxb));
    task automatic final_report;
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(string what, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic hang(int i);
        if (i >= 300) begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        int i;
        i = 0;
        avm <= '{!w, w, a, d};
        do @(posedge clk); while (wreq !== 1'b0 && ++i < 300);
        hang(i);
        q = rdat;
        avm <= '0;
        @(posedge clk);
    endtask
    task automatic send(mhr_ev_t k, mhr_src_t s, logic [9:0] n);
        int i;
        int n0;
        logic [9:0] c;
        i = 0;
        n0 = expq.size();
        c = (n > 10'd999) ? 10'd999 : n;
        if (!mode && k == MHR_EV_REQ)
            expq.push_back(MHR_XOFF);
        if (!mode && k inside {MHR_EV_REQ, MHR_EV_ERROR})
            expq = {expq, (k == MHR_EV_ERROR) ? 8'h65 : lt[s], MHR_ZERO + 8'(c / 100),
                    MHR_ZERO + 8'(c / 10 % 10), MHR_ZERO + 8'(c % 10)};
        else if (!mode)
            expq.push_back(k inside {MHR_EV_DONE, MHR_EV_ITEMWAIT} ? MHR_XON : MHR_XOFF);
        sent += expq.size() - n0;
        if (k inside {MHR_EV_REQ, MHR_EV_SERTERM, MHR_EV_PARFULL, MHR_EV_TIMEOUT})
            busy = 1'b1;
        if (k inside {MHR_EV_DONE, MHR_EV_ITEMWAIT})
            busy = 1'b0;
        evt <= '{1'b1, k, s, n};
        do @(posedge clk); while (erdy !== 1'b1 && ++i < 300);
        hang(i);
        evt.valid <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("pin_oe_n", !(mode && (pos ^ busy)), poe_n);
    endtask
    // expected bytes leave the queue oldest first as the host takes them
    always @(posedge clk)
        if (got === 1'b1)
            cmp("tx_data", expq.size() ? 32'(expq.pop_front()) : 32'h0000_0100, 32'(rxb));
    initial begin
        repeat (90000) @(posedge clk);
        hang(300);
    end
    initial begin
        int i;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        bus(0, MHR_OFS_CTRL, 0);
        cmp("ctrl", 32'h0000_0002, q);
        bus(0, 5'h14, 0);
        cmp("unmapped", 0, q);
        bus(1, MHR_OFS_IRQ_EN, 32'h0000_0001);
        send(MHR_EV_REQ, MHR_SRC_PORT, 10'd101);
        send(MHR_EV_DONE, MHR_SRC_PORT, 0);
        send(MHR_EV_REQ, MHR_SRC_LINK, 10'd102);
        foreach (sq[j]) send(sq[j], MHR_SRC_LINK, 0);
        for (i = 0; i < 12; i++) begin
            send(MHR_EV_REQ, mhr_src_t'(i), 10'($random(seed)));
            send(MHR_EV_DONE, mhr_src_t'(i), 0);
        end
        send(MHR_EV_ERROR, MHR_SRC_ERR, 10'h3FF);
        drain_wait();
        bus(0, MHR_OFS_TXCNT, 0);
        cmp("txcnt", 32'(sent), q);
        cmp("irq", 1, irq);
        bus(0, MHR_OFS_STATUS, 0);
        cmp("status", 32'h0000_000F, q & 32'h0000_030F);
        bus(1, MHR_OFS_IRQ_CLR, 32'h0000_000F);
        bus(0, MHR_OFS_STATUS, 0);
        cmp("status", 0, q & 32'h0000_030F);
        cmp("irq", 0, irq);
        bus(1, MHR_OFS_IRQ_EN, 0);
        for (i = 0; i < 2; i++) begin
            pos = !i[0];
            mode = 1'b1;
            bus(1, MHR_OFS_CTRL, {30'h0, pos, 1'b1});
            send(MHR_EV_REQ, MHR_SRC_TIMER, 10'd7);
            send(MHR_EV_ITEMWAIT, MHR_SRC_TIMER, 0);
            send(MHR_EV_PARFULL, MHR_SRC_TIMER, 0);
            send(MHR_EV_DONE, MHR_SRC_TIMER, 0);
        end
        cmp("irq", 0, irq);
        final_report();
    end
    // nothing new is sent until every expected byte has come and evt_ready is high
    task automatic drain_wait;
        int i;
        i = 0;
        do @(posedge clk); while ((expq.size() != 0 || erdy !== 1'b1) && ++i < 300);
        hang(i);
    endtask
endmodule
